// File: pkg/dbc_map.svh
// timing counts and pin constants of the command-bus controller
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH

`define DBC_CLK_NS   50
`define DBC_TRP_NS   15
`define DBC_TRCD_NS  15
`define DBC_TRFC_NS  72
`define DBC_TMRD_NS  10
`define DBC_TWR_NS   15
`define DBC_TXSNR_NS 80
`define DBC_DLL_CYC  200

// least times round up to whole cycles
`define DBC_CYC(ns)   (((ns) + `DBC_CLK_NS - 1) / `DBC_CLK_NS)
`define DBC_TRP_CYC   `DBC_CYC(`DBC_TRP_NS)
`define DBC_TRCD_CYC  `DBC_CYC(`DBC_TRCD_NS)
`define DBC_TRFC_CYC  `DBC_CYC(`DBC_TRFC_NS)
`define DBC_TMRD_CYC  `DBC_CYC(`DBC_TMRD_NS)
`define DBC_TWR_CYC   `DBC_CYC(`DBC_TWR_NS)
`define DBC_TXSNR_CYC `DBC_CYC(`DBC_TXSNR_NS)

`define DBC_CW       8
`define DBC_AP_BIT   10
`define DBC_NBANK    4
`define DBC_CKE_RST  1'b1

`endif

// File: pkg/dbc_pkg.sv
// types of the command-bus controller
package dbc_pkg;
  typedef enum logic [3:0] {
    C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF, C_MRS, C_BST, C_PDN, C_SRF, C_WAKE
  } dbc_cmd_t;

  typedef struct packed {
    dbc_cmd_t    cmd;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic        dll_off;
  } dbc_req_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } dbc_pins_t;

  typedef enum logic [2:0] {
    B_IDLE, B_ACTV, B_ROW, B_RD, B_WR, B_RDA, B_WRA, B_PRE
  } dbc_bank_t;

  typedef enum logic [1:0] {P_RUN, P_PDN, P_SRF} dbc_pwr_t;
endpackage

// File: hw/dbc_host.sv
// controller that drives the memory command bus and tracks bank state
`include "dbc_map.svh"

// What this block does
// - a bank must be activated before any read or write to it
// - after exit with the lock loop disabled, wait 200 cycles before a read
// - leave power-down with clock enable high plus deselect; command next cycle
// - only deselect during self-refresh exit time, 200 cycles before any read
// - refresh and mode set only when every bank is idle
// - no write while read data is out; wait or stop the burst
// - a write burst takes read, write, precharge; cut data needs masking
// - no command to a bank that is precharging, activating or auto-precharging
// - only deselect during refresh, mode set and precharge-all timings
// - precharge-all only when every bank may legally be precharged
// - unspecified sequences are never issued; such requests are held off
module dbc_host #(
  parameter int BL = 4
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // request stream
  input  wire logic        req_valid,
  output logic             req_ready,
  input  dbc_pkg::dbc_req_t req,
  // memory command pins
  output dbc_pkg::dbc_pins_t pins,
  output logic             dm_mask,
  // status
  output logic             all_idle,
  output dbc_pkg::dbc_pwr_t pwr_state
);
  import dbc_pkg::*;

  localparam int CW = `DBC_CW;
  localparam logic [CW-1:0] BURST = CW'(BL / 2);
  localparam logic [CW-1:0] TRP   = CW'(`DBC_TRP_CYC);
  localparam logic [CW-1:0] TRCD  = CW'(`DBC_TRCD_CYC);
  localparam logic [CW-1:0] TRFC  = CW'(`DBC_TRFC_CYC);
  localparam logic [CW-1:0] TMRD  = CW'(`DBC_TMRD_CYC);
  localparam logic [CW-1:0] TWR   = CW'(`DBC_TWR_CYC);
  localparam logic [CW-1:0] TXSNR = CW'(`DBC_TXSNR_CYC);
  localparam logic [CW-1:0] DLL   = CW'(`DBC_DLL_CYC);
  localparam logic [CW-1:0] ONE   = CW'(1);

  if (!(BL == 2 || BL == 4 || BL == 8)) begin : g_bl_chk
    $error("burst length must be 2, 4 or 8");
  end

  dbc_bank_t                  bank_q [`DBC_NBANK];
  dbc_bank_t                  bank_d [`DBC_NBANK];
  logic [CW-1:0]              bcnt_q [`DBC_NBANK];
  logic [CW-1:0]              bcnt_d [`DBC_NBANK];
  logic [`DBC_NBANK-1:0]      idle_v;
  logic [`DBC_NBANK-1:0]      busy_v;
  logic [`DBC_NBANK-1:0]      prok_v;
  logic [`DBC_NBANK-1:0]      wr_live;
  logic [CW-1:0]              gcnt_q, gcnt_d;
  logic [CW-1:0]              rdcnt_q, rdcnt_d;
  logic [CW-1:0]              dll_q, dll_d;
  logic [1:0]                 lastrd_q, lastrd_d;
  logic                       dlloff_q, dlloff_d;
  dbc_pwr_t                   pwr_q, pwr_d;
  dbc_pins_t                  pins_q, pins_d;
  logic                       dm_q, dm_d;
  logic                       fire;
  logic                       run;
  logic                       ap;
  dbc_bank_t                  bsel;

  assign fire      = req_valid && req_ready;
  assign run       = (pwr_q == P_RUN) && (gcnt_q == '0);
  assign ap        = req.addr[`DBC_AP_BIT];
  assign bsel      = bank_q[req.ba];
  assign all_idle  = (&idle_v) && (gcnt_q == '0);
  assign pins      = pins_q;
  assign dm_mask   = dm_q;
  assign pwr_state = pwr_q;

  for (genvar i = 0; i < `DBC_NBANK; i++) begin : g_bank
    assign idle_v[i]  = (bank_q[i] == B_IDLE);
    assign busy_v[i]  = !(bank_q[i] inside {B_IDLE, B_ROW});
    // a bank mid-timing may not be precharged
    assign prok_v[i]  = bank_q[i] inside {B_IDLE, B_ROW, B_RD, B_WR};
    // write data still arriving, so a cut needs masking
    assign wr_live[i] = (bank_q[i] == B_WR) && (bcnt_q[i] > TWR);

    always_comb begin
      bank_d[i] = bank_q[i];
      bcnt_d[i] = bcnt_q[i];
      case (bank_q[i])
        B_ACTV, B_RD, B_WR, B_RDA, B_WRA, B_PRE: begin
          if (bcnt_q[i] > ONE) begin
            bcnt_d[i] = bcnt_q[i] - ONE;
          end else if (bank_q[i] inside {B_ACTV, B_RD, B_WR}) begin
            bank_d[i] = B_ROW;
          end else begin
            bank_d[i] = B_IDLE;
          end
        end
        default: ;
      endcase
      if (fire) begin
        case (req.cmd)
          C_ACT: if (req.ba == 2'(i)) begin
            bank_d[i] = B_ACTV;
            bcnt_d[i] = TRCD;
          end
          C_RD: if (req.ba == 2'(i)) begin
            bank_d[i] = ap ? B_RDA : B_RD;
            bcnt_d[i] = ap ? BURST + TRP : BURST;
          end
          C_WR: if (req.ba == 2'(i)) begin
            bank_d[i] = ap ? B_WRA : B_WR;
            bcnt_d[i] = ap ? BURST + TWR + TRP : BURST + TWR;
          end
          C_PRE: if ((ap || req.ba == 2'(i)) && bank_q[i] != B_IDLE) begin
            bank_d[i] = B_PRE;
            bcnt_d[i] = TRP;
          end
          C_BST: if (lastrd_q == 2'(i) && bank_q[i] == B_RD) begin
            bank_d[i] = B_ROW;
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        bank_q[i] <= B_IDLE;
        bcnt_q[i] <= '0;
      end else begin
        bank_q[i] <= bank_d[i];
        bcnt_q[i] <= bcnt_d[i];
      end
    end
  end

  // legality of the offered request against the state before the edge
  always_comb begin
    case (req.cmd)
      C_NOP:  req_ready = 1'b1;
      C_ACT:  req_ready = run && bsel == B_IDLE;
      C_RD:   req_ready = run && bsel inside {B_ROW, B_RD, B_WR} && dll_q == '0;
      C_WR:   req_ready = run && bsel inside {B_ROW, B_RD, B_WR} && rdcnt_q == '0;
      C_PRE:  req_ready = run && (ap ? (&prok_v) : prok_v[req.ba]);
      C_REF,
      C_MRS:  req_ready = run && all_idle;
      C_BST:  req_ready = run && bank_q[lastrd_q] == B_RD;
      C_PDN:  req_ready = run && busy_v == '0;
      C_SRF:  req_ready = run && all_idle;
      C_WAKE: req_ready = pwr_q != P_RUN;
      default: req_ready = 1'b0;
    endcase
  end

  always_comb begin
    gcnt_d   = (gcnt_q != '0) ? gcnt_q - ONE : gcnt_q;
    rdcnt_d  = (rdcnt_q != '0) ? rdcnt_q - ONE : rdcnt_q;
    dll_d    = (dll_q != '0 && pwr_q == P_RUN) ? dll_q - ONE : dll_q;
    lastrd_d = lastrd_q;
    dlloff_d = dlloff_q;
    pwr_d    = pwr_q;
    dm_d     = 1'b0;
    // deselect by default; clock enable keeps its level
    pins_d       = pins_q;
    pins_d.cs_n  = 1'b1;
    pins_d.ras_n = 1'b1;
    pins_d.cas_n = 1'b1;
    pins_d.we_n  = 1'b1;
    if (fire && req.cmd inside {C_ACT, C_RD, C_WR, C_PRE, C_REF, C_MRS, C_BST, C_SRF}) begin
      pins_d.cs_n = 1'b0;
      pins_d.ba   = req.ba;
      pins_d.addr = req.addr;
      case (req.cmd)
        C_ACT:   {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b011;
        C_RD:    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b101;
        C_WR:    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b100;
        C_PRE:   {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b010;
        C_BST:   {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b110;
        C_MRS:   {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b000;
        default: {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'b001;
      endcase
    end
    if (fire) begin
      case (req.cmd)
        C_RD: begin
          rdcnt_d  = BURST;
          lastrd_d = req.ba;
          dm_d     = wr_live != '0;
        end
        C_BST: rdcnt_d = '0;
        C_PRE: begin
          dm_d = ap ? (wr_live != '0) : wr_live[req.ba];
          if (ap) begin
            gcnt_d  = TRP;
            rdcnt_d = '0;
          end else if (req.ba == lastrd_q) begin
            rdcnt_d = '0;
          end
        end
        C_REF: gcnt_d = TRFC;
        C_MRS: gcnt_d = TMRD;
        C_PDN: begin
          pins_d.cke = 1'b0;
          dlloff_d   = req.dll_off;
          pwr_d      = P_PDN;
        end
        C_SRF: begin
          pins_d.cke = 1'b0;
          pwr_d      = P_SRF;
        end
        C_WAKE: begin
          // no extra wait after power-down: next cycle is already legal, except a read when the lock loop was disabled
          pins_d.cke = 1'b1;
          pwr_d      = P_RUN;
          if (pwr_q == P_SRF) begin
            gcnt_d = TXSNR;
            dll_d  = DLL;
          end else if (dlloff_q) begin
            dll_d = DLL;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gcnt_q      <= '0;
      rdcnt_q     <= '0;
      dll_q       <= '0;
      lastrd_q    <= '0;
      dlloff_q    <= 1'b0;
      pwr_q       <= P_RUN;
      dm_q        <= 1'b0;
      pins_q      <= '0;
      pins_q.cke  <= `DBC_CKE_RST;
      pins_q.cs_n <= 1'b1;
      pins_q.ras_n <= 1'b1;
      pins_q.cas_n <= 1'b1;
      pins_q.we_n <= 1'b1;
    end else begin
      gcnt_q   <= gcnt_d;
      rdcnt_q  <= rdcnt_d;
      dll_q    <= dll_d;
      lastrd_q <= lastrd_d;
      dlloff_q <= dlloff_d;
      pwr_q    <= pwr_d;
      dm_q     <= dm_d;
      pins_q   <= pins_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  rd_open_row_a: assert property (
    fire && req.cmd == C_RD |-> bsel inside {B_ROW, B_RD, B_WR})
    else $error("read to a bank without an open row");
  pd_cke_low_a: assert property (
    pwr_q == P_PDN && !(fire && req.cmd == C_WAKE) |=> !pins.cke)
    else $error("clock enable rose during power-down");
  dll_wait_a: assert property (
    fire && req.cmd == C_RD |-> dll_q == '0)
    else $error("read issued before lock time");
  exit_desel_a: assert property (
    $rose(pins.cke) |-> pins.cs_n)
    else $error("power-down exit without deselect");
  busy_desel_a: assert property (
    gcnt_q != '0 |=> pins.cs_n)
    else $error("command during refresh, mode set or exit time");
  ref_idle_a: assert property (
    fire && req.cmd inside {C_REF, C_MRS, C_SRF} |-> &idle_v)
    else $error("refresh or mode set with a bank open");
  rd_to_wr_a: assert property (
    fire && req.cmd == C_RD ##1 (req_valid && req.cmd == C_WR) |-> !req_ready)
    else $error("write during read data");
  wr_cut_a: assert property (
    fire && req.cmd == C_PRE && !ap && wr_live[req.ba] |=> dm_mask ##1 !dm_mask)
    else $error("cut write not masked");
  timed_bank_a: assert property (
    fire && req.cmd inside {C_ACT, C_RD, C_WR} |->
      !(bsel inside {B_ACTV, B_PRE, B_RDA, B_WRA}))
    else $error("command to a bank in a timed state");
  prea_legal_a: assert property (
    fire && req.cmd == C_PRE && ap |-> (&prok_v) ##1 (gcnt_q == TRP))
    else $error("precharge-all from an illegal state");

endmodule // dbc_host

// File: test/dbc_mem_model.sv
// behavioural memory device: decodes the pins and counts illegal commands
module dbc_mem_model (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // command pins
  input  dbc_pkg::dbc_pins_t pins,
  // illegal commands seen
  output int                 viol
);
  timeunit 1ns;
  timeprecision 100ps;
  import dbc_pkg::*;

  logic [3:0] open_q;  // row open flag per bank
  logic       cke_q;
  logic [3:0] op;

  assign op = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      open_q <= 4'h0;
      cke_q  <= 1'b1;
      viol   <= 0;
    end else begin
      cke_q <= pins.cke;
      if (!cke_q) begin
        // buffers off: only a clean exit is looked at
        if (pins.cke && !op[3] && op != 4'h7) viol <= viol + 1;
      end else if (!pins.cke) begin
        // refresh on entry needs every bank idle
        if (op == 4'h1 && |open_q) viol <= viol + 1;
      end else if (!op[3]) begin
        case (op[2:0])
          3'h3: begin
            if (open_q[pins.ba]) viol <= viol + 1;
            open_q[pins.ba] <= 1'b1;
          end
          3'h4, 3'h5: begin
            if (!open_q[pins.ba]) viol <= viol + 1;
            if (pins.addr[10]) open_q[pins.ba] <= 1'b0;
          end
          3'h2: begin
            if (pins.addr[10]) open_q <= 4'h0;
            else open_q[pins.ba] <= 1'b0;
          end
          3'h0, 3'h1: if (|open_q) viol <= viol + 1;
          default: ;  // burst stop is not tied to a bank
        endcase
      end
    end
  end
endmodule  // dbc_mem_model

// File: test/dbc_host_tb_top.sv
// self-checking bench of the command-bus controller
`include "dbc_map.svh"
module dbc_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dbc_pkg::*;

  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_ready;
  dbc_req_t   req = '0;
  dbc_pins_t  pins;
  logic       dm_mask;
  logic       all_idle;
  dbc_pwr_t   pwr_state;
  logic [3:0] op;
  int         viol;
  int         bad_count = 0;
  int         tests_run = 0;
  int         w;
  logic       dll_sel = 1'b0;

  assign op = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

  dbc_host #(.BL(4)) dut (
    .clk_sys, .rst_n, .req_valid, .req_ready, .req, .pins, .dm_mask, .all_idle, .pwr_state
  );
  dbc_mem_model mem (.clk_sys, .rst_n, .pins, .viol);

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // offer one request; wait at most n cycles for it to be taken or see it refused
  task automatic go(dbc_cmd_t c, logic [1:0] b, logic [12:0] a, logic ok, int n);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{c, b, a, dll_sel};
    #1;
    for (w = 0; w < n && req_ready !== 1'b1; w++) begin
      @(negedge clk_sys);
      #1;
    end
    chk(req_ready, ok);
    if (ok) begin
      if (req_ready !== 1'b1) give_verdict();
      @(negedge clk_sys);
    end
    req_valid = 1'b0;
  endtask

  // offer one request until taken, then at once a second one in the very next
  // cycle, which must be refused; valid stays up so one-cycle windows are seen
  task automatic go2(dbc_cmd_t c, logic [1:0] b, logic [12:0] a, dbc_cmd_t c2,
                     logic [1:0] b2);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{c, b, a, dll_sel};
    #1;
    for (w = 0; w < 20 && req_ready !== 1'b1; w++) begin
      @(negedge clk_sys);
      #1;
    end
    chk(req_ready, 1'b1);
    if (req_ready !== 1'b1) give_verdict();
    @(negedge clk_sys);
    req = '{c2, b2, 13'h0000, dll_sel};
    #1;
    chk(req_ready, 1'b0);
    req_valid = 1'b0;
  endtask

  task automatic t_codes();
    dbc_cmd_t   c [7] = '{C_REF, C_MRS, C_ACT, C_WR, C_RD, C_BST, C_PRE};
    logic [3:0] e [7] = '{4'h1, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h2};
    for (int i = 0; i < 7; i++) begin
      go(c[i], 2'h0, 13'h0000, 1'b1, 20);
      chk(op, e[i]);
      chk(dm_mask, c[i] == C_RD);
    end
    @(negedge clk_sys);
    chk(op, 4'hf);
  endtask

  task automatic t_refuse();
    go(C_RD, 2'h1, 13'h0000, 1'b0, 0);
    go2(C_ACT, 2'h1, 13'h0000, C_ACT, 2'h1);
    go(C_REF, 2'h0, 13'h0000, 1'b0, 0);
    go(C_RD, 2'h1, 13'h0000, 1'b1, 20);
    go(C_WR, 2'h1, 13'h0000, 1'b0, 0);
    go2(C_PRE, 2'h3, 13'h0400, C_ACT, 2'h2);
    chk(pins.addr[10], 1'b1);
    go(C_ACT, 2'h1, 13'h0000, 1'b1, 20);
  endtask

  task automatic t_autopre();
    go2(C_RD, 2'h1, 13'h0400, C_ACT, 2'h1);
    go(C_ACT, 2'h1, 13'h0000, 1'b1, 20);
    // burst of 4 plus row precharge, less the cycle the probe used up
    chk(w, 4 / 2 + `DBC_TRP_CYC - 1);
  endtask

  task automatic t_pdown();
    dll_sel = 1'b1;
    go(C_PDN, 2'h0, 13'h0000, 1'b1, 20);
    dll_sel = 1'b0;
    chk({pins.cke, pwr_state}, {1'b0, P_PDN});
    go(C_ACT, 2'h2, 13'h0000, 1'b0, 0);
    go(C_WAKE, 2'h0, 13'h0000, 1'b1, 0);
    chk({pins.cke, pins.cs_n, pwr_state}, {2'b11, P_RUN});
    go(C_RD, 2'h1, 13'h0000, 1'b0, 0);
    go(C_WR, 2'h1, 13'h0000, 1'b1, 0);
    go(C_PRE, 2'h1, 13'h0000, 1'b1, 0);
    chk({pins.ba, dm_mask}, {2'h1, 1'b1});
  endtask

  task automatic t_sref();
    go(C_SRF, 2'h0, 13'h0000, 1'b1, 20);
    chk({op, pins.cke, pwr_state}, {4'h1, 1'b0, P_SRF});
    go(C_WAKE, 2'h0, 13'h0000, 1'b1, 0);
    go(C_ACT, 2'h0, 13'h0000, 1'b0, 0);
    go(C_ACT, 2'h0, 13'h0000, 1'b1, 20);
    go(C_RD, 2'h0, 13'h0000, 1'b1, 300);
    chk(w >= 190, 1'b1);
    go(C_PRE, 2'h0, 13'h0000, 1'b1, 20);
  endtask

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    chk({op, pins.cke, all_idle, pwr_state}, {4'hf, 2'b11, P_RUN});
    rst_n = 1'b1;
    t_codes();
    t_refuse();
    t_autopre();
    t_pdown();
    t_sref();
    chk(viol, 0);
    give_verdict();
  end
endmodule  // dbc_host_tb_top
